/* logic/tpo_pkg.sv */
// Constants, register map and helpers for the timer pulse output stage
`default_nettype none

package tpo_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W    = 8;
    localparam logic [7:0]  CTRL_OFS  = 8'h00;
    localparam logic [7:0]  OUTC_OFS  = 8'h04;
    localparam logic [7:0]  CMPA_OFS  = 8'h08;
    localparam logic [7:0]  CMPB_OFS  = 8'h0c;
    localparam logic [7:0]  CNT_OFS   = 8'h10;
    localparam logic [7:0]  STAT_OFS  = 8'h14;
    localparam logic [7:0]  MASK_OFS  = 8'h18;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int unsigned CTRL_RUN_BIT     = 0;
    localparam int unsigned CTRL_WIDTH_BIT   = 1;
    localparam int unsigned CTRL_MODE_LSB    = 2;
    localparam int unsigned CTRL_CLRB_BIT    = 4;
    localparam int unsigned CTRL_CLRCAP_BIT  = 5;
    localparam int unsigned CTRL_ONESHOT_BIT = 6;
    localparam int unsigned CTRL_DIV_LSB     = 8;
    localparam int unsigned OUTC_EN_A_BIT    = 0;
    localparam int unsigned OUTC_POL_A_BIT   = 1;
    localparam int unsigned OUTC_EN_B_BIT    = 2;
    localparam int unsigned OUTC_POL_B_BIT   = 3;
    localparam int unsigned ST_MATCH_A_BIT   = 0;
    localparam int unsigned ST_MATCH_B_BIT   = 1;
    localparam int unsigned ST_WRAP_BIT      = 2;
    localparam int unsigned STAT_W           = 3;

    // ------------------------------------------------------------------
    // Output modes, widths and reset values
    // ------------------------------------------------------------------
    localparam logic [1:0]  MODE_TOGGLE = 2'h0;
    localparam logic [1:0]  MODE_PWM_A  = 2'h1;
    localparam logic [1:0]  MODE_PWM_AB = 2'h2;
    localparam logic [1:0]  MODE_PPG    = 2'h3;
    localparam int unsigned COUNT_W     = 16;
    localparam logic [15:0] FULL_8      = 16'h00ff;
    localparam logic [15:0] FULL_16     = 16'hffff;
    localparam logic [15:0] COUNT_RST   = 16'h0000;
    localparam logic [15:0] CMP_RST     = 16'hffff;
    localparam logic [3:0]  DIV_SEL_MAX = 4'h8;
    localparam logic [11:0] DIV_BASE    = 12'h008;
    localparam logic [10:0] PRE_RST     = 11'h000;

    // Compare value as seen by the counter in the chosen width
    function automatic logic [15:0] cmp_eff(input logic [15:0] v, input logic w16);
        cmp_eff = w16 ? v : {8'h00, v[7:0]};
    endfunction : cmp_eff

endpackage : tpo_pkg

`default_nettype wire

/* logic/tpo_evt_if.sv */
// Counter events shared between the timer core and its output channels
`default_nettype none

interface tpo_evt_if;
    logic run;     // Counter running
    logic wrap;    // Counter restarted at zero, one-cycle pulse
    logic match_a; // Count equals compare A, one-cycle pulse
    logic match_b; // Count equals compare B, one-cycle pulse

    modport src  (output run, output wrap, output match_a, output match_b);
    modport chan (input run, input wrap, input match_a, input match_b);
endinterface : tpo_evt_if

`default_nettype wire

/* logic/tpo_prescaler.sv */
// Count clock enable: peripheral clock divided by 8 to 2048
`default_nettype none

module tpo_prescaler
    import tpo_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    input  wire logic       run_i,
    input  wire logic [3:0] div_sel_i,
    output logic            tick_o
);

    logic [10:0] pre_r;
    logic [10:0] lim;
    logic [3:0]  sel;
    logic [10:0] gap_r;

    // Terminal count, selection above 8 held at 8 (divide by 2048)
    always_comb begin
        sel = (div_sel_i > DIV_SEL_MAX) ? DIV_SEL_MAX : div_sel_i;
        lim = 11'((DIV_BASE << sel) - 12'h001);
    end

    // Divider restarts whenever the counter is stopped
    always_ff @(posedge mclk_i) begin
        if (rst_i || !run_i) begin
            pre_r  <= PRE_RST;
            tick_o <= 1'b0;
        end else begin
            tick_o <= (pre_r == lim);
            pre_r  <= (pre_r == lim) ? PRE_RST : pre_r + 11'h001;
        end
    end

    // Cycles since last tick, for checking only; one below zero while stopped
    // so that the first tick of a run shows the same spacing as later ones
    always_ff @(posedge mclk_i) begin
        if (rst_i || !run_i) begin
            gap_r <= PRE_RST - 11'h001;
        end else if (tick_o) begin
            gap_r <= PRE_RST;
        end else begin
            gap_r <= gap_r + 11'h001;
        end
    end

    tick_gap_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        tick_o && $past(tick_o, 1) == 1'b0 && run_i && $stable(div_sel_i)
            && gap_r != PRE_RST |-> gap_r == lim)
        else $error("count clock spacing differs from selected divider");

endmodule : tpo_prescaler

`default_nettype wire

/* logic/tpo_channel.sv */
// One pulse output pin: toggle or PWM shaping with enable and polarity
`default_nettype none

module tpo_channel (
    input  wire logic   mclk_i,
    input  wire logic   rst_i,
    tpo_evt_if.chan     evt,
    input  wire logic   match_i,
    input  wire logic   pwm_i,
    input  wire logic   en_i,
    input  wire logic   pol_i,
    output logic        pin_o
);

    logic done_r;

    // Pin level: fixed when disabled, ~pol_i in PWM and pol_i in toggle when stopped, shaped when running
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pin_o <= 1'b1;
        end else if (!en_i) begin
            pin_o <= ~pol_i;
        end else if (!evt.run) begin
            pin_o <= pwm_i ? ~pol_i : pol_i;
        end else if (pwm_i) begin
            if (evt.wrap) begin
                pin_o <= ~pol_i;
            end else if (match_i && !done_r) begin
                pin_o <= pol_i;
            end
        end else if (match_i) begin
            pin_o <= ~pin_o;
        end
    end

    // Remembers the one permitted PWM transition in this period
    always_ff @(posedge mclk_i) begin
        if (rst_i || !evt.run || evt.wrap) begin
            done_r <= 1'b0;
        end else if (match_i) begin
            done_r <= 1'b1;
        end
    end

    disabled_level_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        !en_i |=> pin_o == ~$past(pol_i))
        else $error("disabled pin not at inverse polarity");

    pwm_once_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        en_i && pwm_i && evt.run && done_r && !evt.wrap ##1 en_i && $stable(pol_i)
            && evt.run |-> $stable(pin_o))
        else $error("PWM pin changed twice in one period");

    pwm_start_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        en_i && pwm_i && evt.run && evt.wrap |=> pin_o == ~$past(pol_i))
        else $error("PWM pin not active after wrap");

    pwm_stop_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        en_i && pwm_i && !evt.run |=> pin_o == ~$past(pol_i))
        else $error("stopped PWM pin not at active level");

endmodule : tpo_channel

`default_nettype wire

/* logic/tpo_top.sv */
// Timer pulse output stage: APB registers, up-counter and two pulse pins
// What this block does
// - count clock is peripheral clock over 8..2048
// - toggle interval one to 65536 count clocks
// - PWM period is one full pass, compare sets width
// - 8-bit PWM period 256, width equals compare
// - 16-bit PWM period 65536, width equals compare
// - PWM pin changes on compare once per period at most
// - missed compare gives full duty that period
// - stopping during PWM drives the active level
// - disabled pin shows inverse of polarity bit
// - programmable period shapes only output A, B toggles on compare B
// - period compare B plus one, width compare A
// - disabled level high for polarity zero
// - run enable loads zero and starts counting
//
// Implementation choices: the register addresses and the APB register port.
`default_nettype none

module tpo_top
    import tpo_pkg::*;
(
    input  wire logic                  mclk_i,
    input  wire logic                  rst_i,
    input  wire logic                  psel_i,
    input  wire logic                  penable_i,
    input  wire logic                  pwrite_i,
    input  wire logic [tpo_pkg::ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]           pwdata_i,
    output logic      [31:0]           prdata_o,
    output logic                       pready_o,
    output logic                       pslverr_o,
    output logic                       pulse_out_a_o,
    output logic                       pulse_out_b_o,
    output logic                       irq_o
);

    import tpo_pkg::*;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic              count_run_enable_r;
    logic              width_select_r;
    logic [1:0]        mode_r;
    logic              clear_on_compare_b_r;
    logic              clear_on_capture_r;
    logic              one_shot_select_r;
    logic [3:0]        div_sel_r;
    logic              output_enable_a_r;
    logic              polarity_a_r;
    logic              output_enable_b_r;
    logic              polarity_b_r;
    logic [15:0]       compare_a_r;
    logic [15:0]       compare_b_r;
    logic [15:0]       timer_count_r;
    logic [STAT_W-1:0] status_r;
    logic [STAT_W-1:0] mask_r;
    logic              running_r;
    logic              wrap_r;
    logic              match_a_r;
    logic              match_b_r;

    logic              apb_acc;
    logic              apb_wr;
    logic              addr_ok;
    logic              tick;
    logic [15:0]       cnt_last;
    logic [15:0]       cnt_nxt;
    logic [15:0]       cmp_a_eff;
    logic [15:0]       cmp_b_eff;
    logic [STAT_W-1:0] evt_set;
    logic              start;
    logic              pwm_a;
    logic              pwm_b;

    tpo_evt_if evt ();

    // ------------------------------------------------------------------
    // APB slave: one wait state, writes land on the completing edge
    // ------------------------------------------------------------------
    assign apb_acc = psel_i && penable_i;
    assign apb_wr  = apb_acc && pready_o && pwrite_i;

    // Address decode of mapped words
    always_comb begin
        unique case (paddr_i)
            CTRL_OFS, OUTC_OFS, CMPA_OFS, CMPB_OFS,
            CNT_OFS, STAT_OFS, MASK_OFS: addr_ok = 1'b1;
            default:                     addr_ok = 1'b0;
        endcase
    end

    // Ready, error and read data, all registered
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end else if (apb_acc && !pready_o) begin
            pready_o  <= 1'b1;
            pslverr_o <= !addr_ok;
            prdata_o  <= 32'h0000_0000;
            if (!pwrite_i) begin
                unique case (paddr_i)
                    CTRL_OFS: prdata_o <= {20'h00000, div_sel_r, 1'b0,
                                           one_shot_select_r, clear_on_capture_r,
                                           clear_on_compare_b_r, mode_r,
                                           width_select_r, count_run_enable_r};
                    OUTC_OFS: prdata_o <= {28'h0000000, polarity_b_r, output_enable_b_r,
                                           polarity_a_r, output_enable_a_r};
                    CMPA_OFS: prdata_o <= {16'h0000, compare_a_r};
                    CMPB_OFS: prdata_o <= {16'h0000, compare_b_r};
                    CNT_OFS:  prdata_o <= {16'h0000, timer_count_r};
                    STAT_OFS: prdata_o <= {29'h00000000, status_r};
                    MASK_OFS: prdata_o <= {29'h00000000, mask_r};
                    default:  prdata_o <= 32'h0000_0000;
                endcase
            end
        end else begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end
    end

    // Control and output control registers
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            count_run_enable_r   <= 1'b0;
            width_select_r       <= 1'b0;
            mode_r               <= MODE_TOGGLE;
            clear_on_compare_b_r <= 1'b0;
            clear_on_capture_r   <= 1'b0;
            one_shot_select_r    <= 1'b0;
            div_sel_r            <= 4'h0;
            output_enable_a_r    <= 1'b0;
            polarity_a_r         <= 1'b0;
            output_enable_b_r    <= 1'b0;
            polarity_b_r         <= 1'b0;
        end else if (apb_wr && paddr_i == CTRL_OFS) begin
            count_run_enable_r   <= pwdata_i[CTRL_RUN_BIT];
            width_select_r       <= pwdata_i[CTRL_WIDTH_BIT];
            mode_r               <= pwdata_i[CTRL_MODE_LSB +: 2];
            clear_on_compare_b_r <= pwdata_i[CTRL_CLRB_BIT];
            clear_on_capture_r   <= pwdata_i[CTRL_CLRCAP_BIT];
            one_shot_select_r    <= pwdata_i[CTRL_ONESHOT_BIT];
            div_sel_r            <= pwdata_i[CTRL_DIV_LSB +: 4];
        end else if (apb_wr && paddr_i == OUTC_OFS) begin
            output_enable_a_r    <= pwdata_i[OUTC_EN_A_BIT];
            polarity_a_r         <= pwdata_i[OUTC_POL_A_BIT];
            output_enable_b_r    <= pwdata_i[OUTC_EN_B_BIT];
            polarity_b_r         <= pwdata_i[OUTC_POL_B_BIT];
        end
    end

    // Compare registers, rewritable at any time
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            compare_a_r <= CMP_RST;
            compare_b_r <= CMP_RST;
        end else if (apb_wr && paddr_i == CMPA_OFS) begin
            compare_a_r <= pwdata_i[15:0];
        end else if (apb_wr && paddr_i == CMPB_OFS) begin
            compare_b_r <= pwdata_i[15:0];
        end
    end

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    tpo_prescaler u_pre (
        .mclk_i    (mclk_i),
        .rst_i     (rst_i),
        .run_i     (running_r),
        .div_sel_i (div_sel_r),
        .tick_o    (tick)
    );

    assign cmp_a_eff = cmp_eff(compare_a_r, width_select_r);
    assign cmp_b_eff = cmp_eff(compare_b_r, width_select_r);
    assign start     = count_run_enable_r && !running_r;

    // Last count before restart: compare B when clearing on it, else full
    always_comb begin
        if (clear_on_compare_b_r) begin
            cnt_last = cmp_b_eff;
        end else begin
            cnt_last = width_select_r ? FULL_16 : FULL_8;
        end
        cnt_nxt = (timer_count_r == cnt_last) ? COUNT_RST : timer_count_r + 16'h0001;
    end

    // Run state follows the enable; a new run starts from zero
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            running_r     <= 1'b0;
            timer_count_r <= COUNT_RST;
        end else if (!count_run_enable_r) begin
            running_r     <= 1'b0;
            timer_count_r <= COUNT_RST;
        end else if (start) begin
            running_r     <= 1'b1;
            timer_count_r <= COUNT_RST;
        end else if (tick) begin
            timer_count_r <= cnt_nxt;
        end
    end

    // Event pulses, in the same cycle as the count they describe
    always_ff @(posedge mclk_i) begin
        if (rst_i || !count_run_enable_r) begin
            wrap_r    <= 1'b0;
            match_a_r <= 1'b0;
            match_b_r <= 1'b0;
        end else begin
            wrap_r    <= start || (tick && cnt_nxt == COUNT_RST);
            match_a_r <= tick && cnt_nxt == cmp_a_eff;
            match_b_r <= tick && cnt_nxt == cmp_b_eff;
        end
    end

    assign evt.run     = running_r;
    assign evt.wrap    = wrap_r;
    assign evt.match_a = match_a_r;
    assign evt.match_b = match_b_r;

    // ------------------------------------------------------------------
    // Output pins
    // ------------------------------------------------------------------
    assign pwm_a = mode_r != MODE_TOGGLE;
    assign pwm_b = mode_r == MODE_PWM_AB;

    tpo_channel u_chan_a (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .evt     (evt),
        .match_i (match_a_r),
        .pwm_i   (pwm_a),
        .en_i    (output_enable_a_r),
        .pol_i   (polarity_a_r),
        .pin_o   (pulse_out_a_o)
    );

    tpo_channel u_chan_b (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .evt     (evt),
        .match_i (match_b_r),
        .pwm_i   (pwm_b),
        .en_i    (output_enable_b_r),
        .pol_i   (polarity_b_r),
        .pin_o   (pulse_out_b_o)
    );

    // ------------------------------------------------------------------
    // Interrupts: sticky status, write one to clear, set wins
    // ------------------------------------------------------------------
    assign evt_set = {wrap_r && running_r, match_b_r, match_a_r};

    // Sticky status: an event in the clearing cycle stays set
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            status_r <= '0;
        end else if (apb_wr && paddr_i == STAT_OFS) begin
            status_r <= (status_r & ~pwdata_i[STAT_W-1:0]) | evt_set;
        end else begin
            status_r <= status_r | evt_set;
        end
    end

    // Interrupt mask, same layout as status
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            mask_r <= '0;
        end else if (apb_wr && paddr_i == MASK_OFS) begin
            mask_r <= pwdata_i[STAT_W-1:0];
        end
    end

    // Level interrupt while any unmasked status bit is set
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(status_r & mask_r);
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    apb_ready_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        psel_i && penable_i && !pready_o |=> pready_o)
        else $error("APB access not answered in one wait state");

    run_start_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        count_run_enable_r && !running_r |=> running_r && timer_count_r == COUNT_RST)
        else $error("counter did not start from zero");

    wrap_8bit_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        running_r && tick && !width_select_r && !clear_on_compare_b_r
            && timer_count_r == FULL_8 && count_run_enable_r
            |=> timer_count_r == COUNT_RST)
        else $error("8-bit counter did not wrap after 255");

    ppg_period_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        running_r && tick && clear_on_compare_b_r && timer_count_r == cmp_b_eff
            && count_run_enable_r |=> timer_count_r == COUNT_RST ##0 wrap_r)
        else $error("period did not restart after compare B");

    count_step_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        running_r && tick && count_run_enable_r && timer_count_r != cnt_last
            |=> timer_count_r == $past(timer_count_r) + 16'h0001)
        else $error("counter did not advance by one per count clock");

    irq_level_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        ##1 irq_o == |($past(status_r) & $past(mask_r)))
        else $error("interrupt output does not follow masked status");

    status_set_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        match_a_r |=> status_r[ST_MATCH_A_BIT])
        else $error("compare A match lost from status");

    count_stop_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        !count_run_enable_r |=> !running_r && timer_count_r == COUNT_RST)
        else $error("stopped counter not cleared");

    status_b_set_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        match_b_r |=> status_r[ST_MATCH_B_BIT])
        else $error("compare B match lost from status");

    status_clear_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        apb_wr && paddr_i == STAT_OFS && pwdata_i[ST_MATCH_A_BIT] && !match_a_r
            |=> !status_r[ST_MATCH_A_BIT])
        else $error("status bit not cleared by writing one");

endmodule : tpo_top

`default_nettype wire

/* verification/tpo_pulse_meter.sv */
// Bench model of the load on a pulse pin: measures high width and period
`default_nettype none

module tpo_pulse_meter (
    input  wire logic        mclk_i,
    input  wire logic        pin_i,
    output logic      [31:0] high_o,
    output logic      [31:0] period_o
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [31:0] now_r  = 32'h0;
    logic [31:0] rise_r = 32'h0;
    logic        prev_r = 1'b1;

    // Time stamps of pin edges in mclk cycles; a fall closes the high width
    always_ff @(posedge mclk_i) begin
        now_r  <= now_r + 32'h1;
        prev_r <= pin_i;
        if (pin_i && !prev_r) begin
            period_o <= now_r - rise_r;
            rise_r   <= now_r;
        end
        if (!pin_i && prev_r) begin
            high_o <= now_r - rise_r;
        end
    end
endmodule : tpo_pulse_meter

`default_nettype wire

/* verification/timer_pwm_ppg_output_tb_top.sv */
// Self-checking bench of the timer pulse output stage
`default_nettype none

module timer_pwm_ppg_output_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import tpo_pkg::*;

    logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [7:0]  padr = 8'h00, ra;
    logic [31:0] pwd = 32'h0, prdata, rd, hi_a, per_a, hi_b, per_b, seed = 32'd29;
    logic        pready, pslverr, pin_a, pin_b, irq, err;
    int          n_mismatch = 0, compares = 0, cyc = 0;

    tpo_top DUT (.mclk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
        .paddr_i(padr), .pwdata_i(pwd), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .pulse_out_a_o(pin_a), .pulse_out_b_o(pin_b), .irq_o(irq));
    tpo_pulse_meter mon_a (.mclk_i(clk), .pin_i(pin_a), .high_o(hi_a), .period_o(per_a));
    tpo_pulse_meter mon_b (.mclk_i(clk), .pin_i(pin_b), .high_o(hi_b), .period_o(per_b));

    // Clock of 50 ns period
    initial begin
        forever #25 clk = ~clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        xs = t ^ (t << 5);
    endfunction : xs

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic print_verdict;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict

    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_n

    // APB transfer; the answer is taken on the edge that samples pready high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr  <= w;
        padr <= a;
        pwd  <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd  = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask : apb

    // Hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    initial begin
        wait_n(6);
        rst <= 1'b0;
        wait_n(1);
        chk("pin a reset", 32'h1, {31'h0, pin_a});
        chk("pin b reset", 32'h1, {31'h0, pin_b});
        apb(1'b0, CMPA_OFS, 32'h0);
        chk("cmpa reset", 32'hffff, rd);
        apb(1'b0, 8'h1c, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        // Both pins PWM at /8, random width on A, minimum width on B
        seed = xs(seed);
        ra = seed[7:0] | 8'h01;
        apb(1'b1, CMPA_OFS, {24'h0, ra});
        apb(1'b1, CMPB_OFS, 32'h1);
        apb(1'b1, OUTC_OFS, 32'h5);
        apb(1'b1, CTRL_OFS, 32'h9);
        wait_n(6200);
        chk("pwm a width", 32'(ra) * 8, hi_a);
        chk("pwm a period", 32'd2048, per_a);
        chk("pwm b width", 32'd8, hi_b);
        chk("pwm b period", 32'd2048, per_b);
        // Compare lowered below the count in mid-period
        apb(1'b1, CMPA_OFS, 32'hc8);
        @(posedge pin_a);
        wait_n(800);
        apb(1'b1, CMPA_OFS, 32'h14);
        @(negedge pin_a);
        wait_n(2);
        chk("full duty width", 32'd2208, hi_a);
        // Stop while the pin is inactive
        apb(1'b1, CTRL_OFS, 32'h8);
        wait_n(3);
        chk("stopped level", 32'h1, {31'h0, pin_a});
        apb(1'b1, OUTC_OFS, 32'ha);
        wait_n(3);
        chk("disabled a", 32'h0, {31'h0, pin_a});
        chk("disabled b", 32'h0, {31'h0, pin_b});
        // Count clock /16
        apb(1'b1, OUTC_OFS, 32'h5);
        apb(1'b1, CTRL_OFS, 32'h109);
        wait_n(12400);
        chk("div16 period", 32'd4096, per_a);
        chk("div16 width", 32'd320, hi_a);
        apb(1'b1, CTRL_OFS, 32'h108);
        // Programmable period at /2048 with a random width
        seed = xs(seed);
        ra = 8'(seed[9:8] % 2'd3) + 8'h01;
        apb(1'b1, CMPB_OFS, 32'h3);
        apb(1'b1, CMPA_OFS, {24'h0, ra});
        apb(1'b1, MASK_OFS, 32'h0);
        apb(1'b1, CTRL_OFS, 32'h81d);
        wait_n(24700);
        chk("ppg width", 32'(ra) * 2048, hi_a);
        chk("ppg period", 32'd8192, per_a);
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'b1, MASK_OFS, 32'h1);
        wait_n(3);
        chk("irq raised", 32'h1, {31'h0, irq});
        apb(1'b1, CTRL_OFS, 32'h81c);
        apb(1'b1, STAT_OFS, 32'h7);
        wait_n(3);
        chk("irq cleared", 32'h0, {31'h0, irq});
        // A in PWM, B toggling once per full pass; A rewritten from its match interrupt
        apb(1'b1, CTRL_OFS, 32'h5);
        wait_n(4300);
        chk("mode1 a width", 32'(ra) * 8, hi_a);
        chk("mode1 a period", 32'd2048, per_a);
        chk("toggle b level", 32'd2048, hi_b);
        chk("toggle b period", 32'd4096, per_b);
        apb(1'b1, STAT_OFS, 32'h7);
        wait_n(2);
        while (irq !== 1'b1) @(posedge clk);
        apb(1'b1, CMPA_OFS, 32'h40);
        wait_n(4200);
        chk("rewritten width", 32'd512, hi_a);
        print_verdict();
    end
endmodule : timer_pwm_ppg_output_tb_top

`default_nettype wire
